// File: hdl/l2la_ctrl.v
// What this block does
// - Learning unit runs only while enable set
// - Aging unit runs only while enable set
// - DA hit sets hit bit, non-static only
// - Full table: LRU or collision-table overwrite
// - Injected learning packets accepted even with learning disabled
// - Learn result to FIFO; table when commit
// - Aging to FIFO; table when commit set
// - Hit updates to FIFO; table when commit
// - Evict-only option limits aging FIFO pushes
// - Failed port move captured with valid
// - Captured conflict holds until software clears
// - Injected packet needs DA match and accept
// - FIFO read returns and pops oldest entry
// - FIFO takes hardware and injected requests
// - Entry holds MAC, group, destination index
// - Entry holds unicast, port, drop decision
// - Entry holds status and request type
// - Top valid bit shows entry present
// - Watermark pulse when push exceeds level
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`include "l2la_consts.vh"

module l2la_ctrl (
   input wire sys_clk,
   input wire rst,
   input wire [15:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire learn_req,
   input wire [47:0] learn_req_da,
   input wire [47:0] learn_mac,
   input wire [15:0] learn_gid,
   input wire [12:0] learn_dest_table_index,
   input wire learn_unicast_flag,
   input wire [5:0] learn_port_or_ptr,
   input wire learn_drop,
   input wire [2:0] learn_status,
   input wire hit_req,
   input wire hit_static,
   input wire age_req,
   input wire age_evict,
   input wire conflict_req,
   input wire [47:0] conflict_mac,
   input wire [11:0] conflict_gid,
   input wire [3:0] conflict_port,
   output reg learn_unit_on,
   output reg age_unit_on,
   output reg dest_hit_refresh_on,
   output reg learn_evict_lru,
   output reg learn_fib_wr,
   output reg age_fifo_push,
   output reg age_fib_wr,
   output reg hit_set,
   output reg hit_fifo_push,
   output reg hit_fib_wr,
   output reg learn_fifo_hiwater
);

   reg [3:0] learn_age_enable;
   reg [3:0] learn_age_writeback_ctrl;
   reg [48:0] injected_learn_dest_mac;
   reg [64:0] learning_conflict_capture;
   reg [5:0] hiwater_level;
   reg fifo_overflow;
   reg [`L2LA_ENT_W-1:0] fifo_mem [0:`L2LA_FIFO_DEPTH-1];
   reg [`L2LA_FIFO_AW-1:0] wr_ptr;
   reg [`L2LA_FIFO_AW-1:0] rd_ptr;
   reg [`L2LA_FIFO_CW-1:0] fifo_count;
   reg [`L2LA_ENT_W:0] fifo_hold;
   reg [31:0] next_readdata;

   wire [13:0] word_idx;
   wire bus_go;
   wire rd_go;
   wire wr_go;
   wire fifo_empty;
   wire fifo_full;
   wire inj_match;
   wire learn_take;
   wire do_push;
   wire do_pop;
   wire [`L2LA_ENT_W-1:0] new_entry;
   wire [`L2LA_ENT_W:0] head_word;
   wire [`L2LA_FIFO_CW-1:0] count_after;
   wire conf_clear;
   wire hit_take;
   wire age_take;

   function sel;
      input [13:0] idx;
      input [13:0] want;
      begin
         sel = (idx == want);
      end
   endfunction

   assign word_idx = avs_address[15:2];
   // Act once per request, in the cycle before waitrequest drops
   assign bus_go = avs_waitrequest & (avs_read | avs_write);
   assign rd_go = bus_go & avs_read;
   assign wr_go = bus_go & avs_write & ~avs_read;

   assign fifo_empty = (fifo_count == 6'h00);
   assign fifo_full = (fifo_count == 6'h20);

   assign inj_match = (learn_req_da ==
      injected_learn_dest_mac[47:0]) &
      injected_learn_dest_mac[`L2LA_INJ_ACCEPT];
   // Injected packets pass regardless of learning enable
   assign learn_take = learn_req & (inj_match |
      learn_age_enable[`L2LA_EN_LEARN]);

   assign new_entry = {inj_match, learn_status, 18'h00000,
      learn_drop, learn_port_or_ptr, learn_unicast_flag,
      learn_dest_table_index, learn_gid, learn_mac};

   assign do_push = learn_take & ~fifo_full;
   assign do_pop = rd_go & sel(word_idx, `L2LA_IDX_FIFO0) &
      ~fifo_empty;
   assign head_word = fifo_empty ? {(`L2LA_ENT_W+1){1'b0}} :
      {1'b1, fifo_mem[rd_ptr]};
   assign count_after = fifo_count + 6'h01 -
      {5'h00, do_pop};

   assign conf_clear = wr_go & sel(word_idx, `L2LA_IDX_CONFLICT0) &
      ~avs_writedata[0];
   assign hit_take = hit_req & ~hit_static &
      learn_age_enable[`L2LA_EN_HIT];
   assign age_take = age_req & learn_age_enable[`L2LA_EN_AGE];

   always @* begin
      next_readdata = 32'h0000_0000;
      if (sel(word_idx, `L2LA_IDX_CONFLICT0)) begin
         next_readdata = learning_conflict_capture[31:0];
      end else if (sel(word_idx, `L2LA_IDX_CONFLICT1)) begin
         next_readdata = learning_conflict_capture[63:32];
      end else if (sel(word_idx, `L2LA_IDX_CONFLICT2)) begin
         next_readdata = {31'h0, learning_conflict_capture[64]};
      end else if (sel(word_idx, `L2LA_IDX_ENABLE)) begin
         next_readdata = {28'h000_0000, learn_age_enable};
      end else if (sel(word_idx, `L2LA_IDX_WBCTRL)) begin
         next_readdata = {28'h000_0000, learn_age_writeback_ctrl};
      end else if (sel(word_idx, `L2LA_IDX_HIWATER)) begin
         next_readdata = {26'h0, hiwater_level};
      end else if (sel(word_idx, `L2LA_IDX_INJ_MAC_LO)) begin
         next_readdata = injected_learn_dest_mac[31:0];
      end else if (sel(word_idx, `L2LA_IDX_INJ_MAC_HI)) begin
         next_readdata = {15'h0, injected_learn_dest_mac[48:32]};
      end else if (sel(word_idx, `L2LA_IDX_FIFO_STAT)) begin
         next_readdata = {16'h0000, 7'h00, fifo_overflow,
            2'h0, fifo_count};
      end else if (sel(word_idx, `L2LA_IDX_FIFO0)) begin
         next_readdata = head_word[31:0];
      end else if (sel(word_idx, `L2LA_IDX_FIFO1)) begin
         next_readdata = fifo_hold[63:32];
      end else if (sel(word_idx, `L2LA_IDX_FIFO2)) begin
         next_readdata = fifo_hold[95:64];
      end else if (sel(word_idx, `L2LA_IDX_FIFO3)) begin
         next_readdata = {20'h0_0000, fifo_hold[107:96]};
      end
   end

   // Bus handshake: one wait cycle, then one cycle of answer
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else if (bus_go) begin
         avs_waitrequest <= 1'b0;
         if (avs_read) begin
            avs_readdata <= next_readdata;
         end
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // Software control registers
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         learn_age_enable <= `L2LA_ENABLE_RST;
         learn_age_writeback_ctrl <= `L2LA_WBCTRL_RST;
         injected_learn_dest_mac <= `L2LA_INJ_RST;
         hiwater_level <= `L2LA_HIWATER_RST;
      end else if (wr_go) begin
         if (sel(word_idx, `L2LA_IDX_ENABLE)) begin
            learn_age_enable <= avs_writedata[3:0];
         end else if (sel(word_idx, `L2LA_IDX_WBCTRL)) begin
            learn_age_writeback_ctrl <= avs_writedata[3:0];
         end else if (sel(word_idx, `L2LA_IDX_HIWATER)) begin
            hiwater_level <= avs_writedata[5:0];
         end else if (sel(word_idx, `L2LA_IDX_INJ_MAC_LO)) begin
            injected_learn_dest_mac[31:0] <= avs_writedata;
         end else if (sel(word_idx, `L2LA_IDX_INJ_MAC_HI)) begin
            injected_learn_dest_mac[48:32] <= avs_writedata[16:0];
         end
      end
   end

   // Conflict capture; a new failure wins over a clear
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         learning_conflict_capture <= `L2LA_CONF_RST;
      end else if (conflict_req &
         (~learning_conflict_capture[`L2LA_CONF_VALID] |
         conf_clear)) begin
         learning_conflict_capture <= {conflict_port, conflict_gid,
            conflict_mac, 1'b1};
      end else if (conf_clear) begin
         learning_conflict_capture[`L2LA_CONF_VALID] <= 1'b0;
      end
   end

   // Learning result FIFO storage
   always @(posedge sys_clk) begin
      if (do_push) begin
         fifo_mem[wr_ptr] <= new_entry;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= 5'h00;
         rd_ptr <= 5'h00;
         fifo_count <= 6'h00;
         fifo_hold <= {(`L2LA_ENT_W+1){1'b0}};
         fifo_overflow <= 1'b0;
         learn_fifo_hiwater <= 1'b0;
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + 5'h01;
         end
         if (do_pop) begin
            rd_ptr <= rd_ptr + 5'h01;
         end
         if (do_push & ~do_pop) begin
            fifo_count <= fifo_count + 6'h01;
         end else if (do_pop & ~do_push) begin
            fifo_count <= fifo_count - 6'h01;
         end
         // Upper words of a read come from the popped entry
         if (rd_go & sel(word_idx, `L2LA_IDX_FIFO0)) begin
            fifo_hold <= head_word;
         end
         if (learn_take & fifo_full) begin
            fifo_overflow <= 1'b1;
         end else if (wr_go & sel(word_idx, `L2LA_IDX_FIFO_STAT) &
            avs_writedata[9]) begin
            fifo_overflow <= 1'b0;
         end
         learn_fifo_hiwater <= do_push &
            (count_after > hiwater_level);
      end
   end

   // Pipeline-facing decisions, one cycle after each request
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         learn_unit_on <= 1'b1;
         age_unit_on <= 1'b1;
         dest_hit_refresh_on <= 1'b1;
         learn_evict_lru <= 1'b0;
         learn_fib_wr <= 1'b0;
         age_fifo_push <= 1'b0;
         age_fib_wr <= 1'b0;
         hit_set <= 1'b0;
         hit_fifo_push <= 1'b0;
         hit_fib_wr <= 1'b0;
      end else begin
         learn_unit_on <= learn_age_enable[`L2LA_EN_LEARN];
         age_unit_on <= learn_age_enable[`L2LA_EN_AGE];
         dest_hit_refresh_on <= learn_age_enable[`L2LA_EN_HIT];
         learn_evict_lru <= learn_age_enable[`L2LA_EN_LRU];
         // Injected results always reach the tables
         learn_fib_wr <= learn_take & (inj_match |
            learn_age_writeback_ctrl[`L2LA_WB_LEARN]);
         age_fifo_push <= age_take & (age_evict |
            ~learn_age_writeback_ctrl[`L2LA_WB_EVICT_ONLY]);
         age_fib_wr <= age_take &
            learn_age_writeback_ctrl[`L2LA_WB_AGE];
         hit_set <= hit_take &
            learn_age_writeback_ctrl[`L2LA_WB_HIT];
         hit_fifo_push <= hit_take;
         hit_fib_wr <= hit_take &
            learn_age_writeback_ctrl[`L2LA_WB_HIT];
      end
   end

endmodule

// File: hdl/l2la_consts.vh
`ifndef L2LA_CONSTS_VH
`define L2LA_CONSTS_VH

// Register word indices; byte address is four times the index
`define L2LA_IDX_CONFLICT0 14'h0126
`define L2LA_IDX_CONFLICT1 14'h0127
`define L2LA_IDX_CONFLICT2 14'h0128
`define L2LA_IDX_CONFLICT3 14'h0129
`define L2LA_IDX_ENABLE 14'h012E
`define L2LA_IDX_WBCTRL 14'h0130
`define L2LA_IDX_HIWATER 14'h0131
`define L2LA_IDX_INJ_MAC_LO 14'h0300
`define L2LA_IDX_INJ_MAC_HI 14'h0301
`define L2LA_IDX_FIFO_STAT 14'h0302
`define L2LA_IDX_FIFO0 14'h116D
`define L2LA_IDX_FIFO1 14'h116E
`define L2LA_IDX_FIFO2 14'h116F
`define L2LA_IDX_FIFO3 14'h1170

// Enable register fields
`define L2LA_EN_LEARN 0
`define L2LA_EN_AGE 1
`define L2LA_EN_HIT 2
`define L2LA_EN_LRU 3
`define L2LA_ENABLE_RST 4'h7

// Writeback control fields
`define L2LA_WB_LEARN 0
`define L2LA_WB_AGE 1
`define L2LA_WB_HIT 2
`define L2LA_WB_EVICT_ONLY 3
`define L2LA_WBCTRL_RST 4'h7

// Injected learning address register
`define L2LA_INJ_ACCEPT 48
`define L2LA_INJ_RST 49'h0

// Conflict capture fields
`define L2LA_CONF_VALID 0
`define L2LA_CONF_RST 65'h0

// Learning result entry fields
`define L2LA_ENT_W 107
`define L2LA_ENT_TYPE 106
`define L2LA_ENT_VALID 107
`define L2LA_HIWATER_RST 6'h00

// Learning result FIFO geometry
`define L2LA_FIFO_AW 5
`define L2LA_FIFO_DEPTH 32
`define L2LA_FIFO_CW 6

`endif

// File: testbench/l2la_ctrl_checker.sv
`timescale 1ns/1ps
module l2la_ctrl_checker (
   input sys_clk,
   input rst,
   input avs_read, avs_write, avs_waitrequest,
   input learn_req, hit_req, hit_static, age_req, age_evict,
   input learn_unit_on, age_unit_on, dest_hit_refresh_on, learn_evict_lru,
   input learn_fib_wr, age_fifo_push, age_fib_wr,
   input hit_set, hit_fifo_push, hit_fib_wr
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer");
   AST_RESET_ON: assert property ($past(rst) |-> learn_unit_on && age_unit_on
      && dest_hit_refresh_on && !learn_evict_lru) else $error("reset");
   AST_AGE_OFF: assert property (age_req && !age_unit_on
      |=> !age_fifo_push && !age_fib_wr) else $error("age while off");
   AST_AGE_EVICT: assert property (age_req && age_evict && age_unit_on
      |=> age_fifo_push) else $error("evict not pushed");
   AST_AGE_CAUSE: assert property (!age_req
      |=> !age_fifo_push && !age_fib_wr) else $error("stray age");
   AST_HIT_STATIC: assert property (hit_req && hit_static
      |=> !hit_set && !hit_fifo_push) else $error("static hit");
   AST_HIT_PUSH: assert property (hit_req && !hit_static && dest_hit_refresh_on
      |=> hit_fifo_push) else $error("hit not pushed");
   AST_HIT_SET: assert property (hit_set |-> hit_fib_wr && hit_fifo_push)
      else $error("hit set alone");
   AST_LEARN_CAUSE: assert property (learn_fib_wr |-> $past(learn_req))
      else $error("stray learn write");
   cover property (hit_set);
   cover property (age_fifo_push && !age_fib_wr);
   cover property (learn_fib_wr);
endmodule
bind l2la_ctrl l2la_ctrl_checker chk_i (.*);

// File: testbench/l2la_pipe_model.sv
`timescale 1ns/1ps
module l2la_pipe_model (
   input sys_clk,
   output reg learn_req, learn_unicast_flag, learn_drop,
   output reg [47:0] learn_req_da, learn_mac, conflict_mac,
   output reg [15:0] learn_gid,
   output reg [12:0] learn_dest_table_index,
   output reg [5:0] learn_port_or_ptr,
   output reg [2:0] learn_status,
   output reg hit_req, hit_static, age_req, age_evict, conflict_req,
   output reg [11:0] conflict_gid,
   output reg [3:0] conflict_port
);
   initial begin
      {learn_req, learn_req_da, learn_mac, learn_gid} = 113'h0;
      {learn_dest_table_index, learn_unicast_flag, learn_port_or_ptr} = 20'h0;
      {learn_drop, learn_status, hit_req, hit_static, age_req} = 7'h0;
      {age_evict, conflict_req, conflict_mac, conflict_gid} = 62'h0;
      conflict_port = 4'h0;
   end
   // DA and MAC fields are scrambled once the request drops
   task learn(input [47:0] da, input [47:0] mac, input [15:0] gid);
      begin
         @(posedge sys_clk);
         {learn_req, learn_req_da, learn_mac, learn_gid} <= {1'h1, da, mac, gid};
         learn_dest_table_index <= mac[12:0];
         {learn_drop, learn_port_or_ptr, learn_unicast_flag} <= 8'hAA;
         learn_status <= 3'h5;
         @(posedge sys_clk);
         {learn_req, learn_req_da, learn_mac} <= {1'h0, ~da, ~mac};
      end
   endtask
   // Kind 0 hit, 1 age, 2 conflict
   task pulse(input [1:0] k, input f, input [47:0] m);
      begin
         @(posedge sys_clk);
         {hit_req, age_req, conflict_req} <= {k == 2'h0, k == 2'h1, k == 2'h2};
         {hit_static, age_evict, conflict_mac} <= {f, f, m};
         {conflict_gid, conflict_port} <= m[15:0];
         @(posedge sys_clk);
         {hit_req, age_req, conflict_req, hit_static, age_evict} <= {3'h0, ~f, ~f};
         conflict_mac <= ~m;
      end
   endtask
endmodule

// File: testbench/l2la_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "l2la_consts.vh"
module l2la_ctrl_tb_top;
   reg sys_clk = 1'h0, rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
   reg [15:0] avs_address = 16'h0;
   reg [31:0] avs_writedata = 32'h0, d;
   reg [127:0] e;
   integer miscompares = 0, n_checks = 0, cyc = 0;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, learn_req, learn_unicast_flag, learn_drop, hit_req;
   wire hit_static, age_req, age_evict, conflict_req, learn_unit_on, hit_set;
   wire age_unit_on, dest_hit_refresh_on, learn_evict_lru, learn_fib_wr;
   wire age_fifo_push, age_fib_wr, hit_fifo_push, hit_fib_wr, learn_fifo_hiwater;
   wire [47:0] learn_req_da, learn_mac, conflict_mac;
   wire [15:0] learn_gid;
   wire [12:0] learn_dest_table_index;
   wire [5:0] learn_port_or_ptr;
   wire [2:0] learn_status;
   wire [11:0] conflict_gid;
   wire [3:0] conflict_port;
   l2la_ctrl dut (.*);
   l2la_pipe_model pm (.*);
   initial forever #20 sys_clk = ~sys_clk;
   task give_verdict;
      begin
         if (miscompares == 0 && n_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         miscompares = miscompares + 1;
         give_verdict;
      end
   end
   task chk(input [127:0] got, input [127:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD %0t %h %h", $time, got, exp);
         end
      end
   endtask
   task bus(input wr, input [13:0] i, input [31:0] wd);
      begin
         @(posedge sys_clk);
         {avs_address, avs_writedata, avs_read, avs_write} <= {i, 2'h0, wd, !wr, wr};
         @(posedge sys_clk);
         while (avs_waitrequest !== 1'h0) @(posedge sys_clk);
         d = avs_readdata;
         {avs_read, avs_write} <= 2'h0;
      end
   endtask
   task entry;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            bus(1'h0, `L2LA_IDX_FIFO0 + k[13:0], 32'h0);
            e[32*k +: 32] = d;
         end
      end
   endtask
   function [127:0] ent(input [47:0] mac, input [15:0] gid, input t);
      ent = {20'h0, 1'h1, t, 3'h5, 18'h0, 8'hAA, mac[12:0], gid, mac};
   endfunction
   task t_reset;
      begin
         chk({learn_unit_on, age_unit_on, dest_hit_refresh_on, learn_evict_lru}, 4'hE);
         bus(1'h0, `L2LA_IDX_ENABLE, 32'h0);
         chk(d, 32'h7);
         bus(1'h0, `L2LA_IDX_WBCTRL, 32'h0);
         chk(d, 32'h7);
         bus(1'h0, `L2LA_IDX_INJ_MAC_HI, 32'h0);
         chk(d, 32'h0);
         bus(1'h0, 14'h0200, 32'h0);
         chk(d, 32'h0);
      end
   endtask
   task t_learn;
      begin
         pm.learn(48'h0, 48'hA1B2C3D4E5F6, 16'h1234);
         #1 chk({learn_fib_wr, learn_fifo_hiwater}, 2'h3);
         pm.learn(48'h0, 48'h010203040506, 16'hBEEF);
         bus(1'h1, `L2LA_IDX_WBCTRL, 32'h6);
         pm.learn(48'h0, 48'h0000000ABCDE, 16'h0042);
         #1 chk(learn_fib_wr, 1'h0);
         entry;
         chk(e, ent(48'hA1B2C3D4E5F6, 16'h1234, 1'h0));
         entry;
         chk(e, ent(48'h010203040506, 16'hBEEF, 1'h0));
         entry;
         chk(e, ent(48'h0000000ABCDE, 16'h0042, 1'h0));
         entry;
         chk(e, 128'h0);
      end
   endtask
   task t_inject;
      begin
         bus(1'h1, `L2LA_IDX_ENABLE, 32'h0);
         #1 chk({learn_unit_on, age_unit_on, dest_hit_refresh_on, learn_evict_lru}, 4'h0);
         bus(1'h1, `L2LA_IDX_INJ_MAC_LO, 32'h1);
         bus(1'h1, `L2LA_IDX_INJ_MAC_HI, 32'h1AA55);
         pm.pulse(2'h1, 1'h1, 48'h0);
         pm.learn(48'hAA5500000001, 48'h1111, 16'h0002);
         #1 chk(learn_fib_wr, 1'h1);
         pm.learn(48'hAA5500000002, 48'h2222, 16'h0003);
         bus(1'h1, `L2LA_IDX_INJ_MAC_HI, 32'hAA55);
         pm.learn(48'hAA5500000001, 48'h3333, 16'h0004);
         entry;
         chk(e, ent(48'h1111, 16'h0002, 1'h1));
         entry;
         chk(e, 128'h0);
         bus(1'h1, `L2LA_IDX_ENABLE, 32'h8);
         #1 chk({learn_unit_on, age_unit_on, dest_hit_refresh_on, learn_evict_lru}, 4'h1);
         bus(1'h1, `L2LA_IDX_ENABLE, 32'h7);
         bus(1'h1, `L2LA_IDX_WBCTRL, 32'h7);
      end
   endtask
   task t_hitage;
      begin
         pm.pulse(2'h0, 1'h1, 48'h0);
         pm.pulse(2'h0, 1'h0, 48'h0);
         #1 chk(hit_set, 1'h1);
         pm.pulse(2'h1, 1'h0, 48'h0);
         #1 chk({age_fifo_push, age_fib_wr}, 2'h3);
         bus(1'h1, `L2LA_IDX_WBCTRL, 32'h8);
         pm.pulse(2'h1, 1'h0, 48'h0);
         #1 chk(age_fifo_push, 1'h0);
         pm.pulse(2'h1, 1'h1, 48'h0);
         #1 chk({age_fifo_push, age_fib_wr}, 2'h2);
         pm.pulse(2'h0, 1'h0, 48'h0);
         #1 chk({hit_fifo_push, hit_fib_wr}, 2'h2);
      end
   endtask
   task t_conflict;
      begin
         pm.pulse(2'h2, 1'h0, 48'h800000000003);
         bus(1'h0, `L2LA_IDX_CONFLICT0, 32'h0);
         chk(d, 32'h7);
         bus(1'h0, `L2LA_IDX_CONFLICT1, 32'h0);
         chk(d, 32'h6001_0000);
         pm.pulse(2'h2, 1'h0, 48'h5);
         bus(1'h0, `L2LA_IDX_CONFLICT0, 32'h0);
         chk(d, 32'h7);
         bus(1'h1, `L2LA_IDX_CONFLICT0, 32'h0);
         pm.pulse(2'h2, 1'h0, 48'h5);
         bus(1'h0, `L2LA_IDX_CONFLICT0, 32'h0);
         chk(d, 32'hB);
      end
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'h0;
      t_reset;
      t_learn;
      t_inject;
      t_hitage;
      t_conflict;
      give_verdict;
   end
endmodule
